// ### src/sar_irq.sv
/*
 * Slot interrupt autoclear and routing: sticky status flags, read
 * autoclear enables and interrupt X routing enables behind AHB-Lite.
 * Assumes event and read strobes are one-cycle pulses on clk, and a single
 * AHB-Lite master; the slave never inserts wait states.
 */
module sar_irq
	import sar_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire sar_events_t events,
	input wire sar_reads_t reads,
	output logic irq_x
);
	logic [15:0] status;
	logic [15:0] aclear;
	logic [15:0] route;
	logic [15:0] next_status;
	logic [15:0] next_aclear;
	logic [15:0] next_route;
	logic [31:0] next_hrdata;
	logic next_irq_x;

	// captured address phase
	logic wr_pend;
	logic [9:0] wr_addr;

	// address phase decode
	wire logic addr_valid = hsel & hready & (htrans == SAR_HTRANS_NONSEQ || htrans == SAR_HTRANS_SEQ);
	wire logic addr_word = (hsize == 3'h2) & (haddr[31:10] == 22'h000000);
	wire logic rd_take = addr_valid & ~hwrite;
	wire logic wr_take = addr_valid & hwrite & addr_word;

	// data phase write strobes
	wire logic wr_status = wr_pend & (wr_addr == SAR_ADDR_STATUS);
	wire logic wr_aclear = wr_pend & (wr_addr == SAR_ADDR_ACLEAR);
	wire logic wr_route = wr_pend & (wr_addr == SAR_ADDR_ROUTE);
	wire logic [15:0] wdata16 = hwdata[15:0];

	// the slave is always ready and always answers okay
	assign hreadyout = 1'b1;
	assign hresp = SAR_HRESP_OKAY;

	// hardware set and autoclear vectors in status layout
	wire logic [15:0] set_vec = {events.fifo_level, events.fifo_empty_read, events.fifo_overrun,
		1'b0, events.slot_ready};
	wire logic [15:0] read_vec = {reads.fifo_read, 3'b000, reads.slot_read};
	wire logic [15:0] auto_clr = read_vec & aclear;
	wire logic [15:0] sw_clr = wr_status ? wdata16 : 16'h0000;

	// per-flag update; a set in the clear cycle wins so no event is lost
	genvar i;
	generate
		for (i = 0; i < SAR_REG_W; i++) begin : g_flag
			assign next_status[i] = SAR_STATUS_MASK[i] &
				(set_vec[i] | (status[i] & ~(auto_clr[i] | sw_clr[i])));
		end
	endgenerate

	// configuration registers take whole writes, reserved bits held at zero
	assign next_aclear = wr_aclear ? (wdata16 & SAR_ACLEAR_MASK) : aclear;
	assign next_route = wr_route ? (wdata16 & SAR_ROUTE_MASK) : route;

	// routing: fifo flags at 15..13, slots L..E at 11..4, D..A at 3..0
	wire logic fifo_level_x = status[SAR_BIT_FIFO_LEVEL] & route[SAR_BIT_FIFO_LEVEL];
	wire logic fifo_empty_read_x = status[SAR_BIT_FIFO_EMPTY_READ] & route[SAR_BIT_FIFO_EMPTY_READ];
	wire logic fifo_overrun_x = status[SAR_BIT_FIFO_OVERRUN] & route[SAR_BIT_FIFO_OVERRUN];
	wire logic slots_high_x = |(status[SAR_BIT_SLOT_L:4] & route[SAR_BIT_SLOT_L:4]);
	wire logic slots_low_x = |(status[3:0] & route[3:0]);
	assign next_irq_x = fifo_level_x | fifo_empty_read_x | fifo_overrun_x | slots_high_x | slots_low_x;

	// read mux; unmapped or unaligned addresses read as zero
	wire logic [9:0] rd_addr = haddr[9:0];
	wire logic rd_status = addr_word & (rd_addr == SAR_ADDR_STATUS);
	wire logic rd_aclear = addr_word & (rd_addr == SAR_ADDR_ACLEAR);
	wire logic rd_route = addr_word & (rd_addr == SAR_ADDR_ROUTE);
	wire logic [15:0] rd_word = rd_status ? status : rd_aclear ? aclear : rd_route ? route : 16'h0000;
	assign next_hrdata = rd_take ? {16'h0000, rd_word} : hrdata;

	// bus phase tracking
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend <= 1'b0;
			wr_addr <= 10'h000;
		end else if (hready) begin
			wr_pend <= wr_take;
			wr_addr <= haddr[9:0];
		end
	end

	// read data is fetched in the address phase so it stands with no wait state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else begin
			hrdata <= next_hrdata;
		end
	end

	// flags and configuration
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status <= SAR_STATUS_RST;
			aclear <= SAR_ACLEAR_RST;
			route <= SAR_ROUTE_RST;
		end else begin
			status <= next_status;
			aclear <= next_aclear;
			route <= next_route;
		end
	end

	// registered level output, one cycle behind the flags, glitch free on the pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_x <= 1'b0;
		end else begin
			irq_x <= next_irq_x;
		end
	end
endmodule : sar_irq

// ### src/sar_pkg.sv
/*
 * Constants, register map and carrier types for the slot interrupt
 * autoclear and routing block.
 * Assumes one 40 MHz clock, an AHB-Lite register bus with 32-bit data,
 * and event and read strobes that come from logic on the same clock.
 */
// Function
// - slot data read clears slot flag if enabled
// - slot autoclear bits reset to one, read/write
// - bit 15 routes fifo level flag
// - bit 14 routes fifo empty-read flag
// - bit 13 routes fifo overrun flag
// - bits 11..4 route slot L..E ready flags
// - routing bits reset to zero, read/write
// - fifo read clears level flag if enabled
// - slot L read clears its flag if enabled
// - bits 3..0 route slot D..A ready flags
package sar_pkg;
	localparam int unsigned SAR_SLOTS = 12;
	localparam int unsigned SAR_REG_W = 16;

	// register indices; byte address is four times the index
	localparam logic [7:0] SAR_IDX_STATUS = 8'h01;
	localparam logic [7:0] SAR_IDX_ACLEAR = 8'h07;
	localparam logic [7:0] SAR_IDX_ROUTE = 8'h14;
	localparam logic [9:0] SAR_ADDR_STATUS = {SAR_IDX_STATUS, 2'b00};
	localparam logic [9:0] SAR_ADDR_ACLEAR = {SAR_IDX_ACLEAR, 2'b00};
	localparam logic [9:0] SAR_ADDR_ROUTE = {SAR_IDX_ROUTE, 2'b00};

	// field positions, common to status, autoclear and routing words
	localparam int unsigned SAR_BIT_FIFO_LEVEL = 15;
	localparam int unsigned SAR_BIT_FIFO_EMPTY_READ = 14;
	localparam int unsigned SAR_BIT_FIFO_OVERRUN = 13;
	localparam int unsigned SAR_BIT_SLOT_L = 11;

	// writable bit masks; the rest reads as zero
	localparam logic [15:0] SAR_STATUS_MASK = 16'hefff;
	localparam logic [15:0] SAR_ACLEAR_MASK = 16'h8fff;
	localparam logic [15:0] SAR_ROUTE_MASK = 16'hefff;

	// reset values
	localparam logic [15:0] SAR_ACLEAR_RST = 16'h8fff;
	localparam logic [15:0] SAR_ROUTE_RST = 16'h0000;
	localparam logic [15:0] SAR_STATUS_RST = 16'h0000;

	// ahb-lite encodings
	localparam logic [1:0] SAR_HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] SAR_HTRANS_SEQ = 2'b11;
	localparam logic SAR_HRESP_OKAY = 1'b0;

	// hardware events, one-cycle pulses
	typedef struct packed {
		logic fifo_level;
		logic fifo_empty_read;
		logic fifo_overrun;
		logic [SAR_SLOTS-1:0] slot_ready;
	} sar_events_t;

	// data-path read strobes, one-cycle pulses
	typedef struct packed {
		logic fifo_read;
		logic [SAR_SLOTS-1:0] slot_read;
	} sar_reads_t;
endpackage : sar_pkg

// ### test/sar_host.sv
/* host model: single-word ahb-lite master. assumes one slave drives hready. */
module sar_host
	import sar_pkg::*;
(
	input wire logic clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// only word transfers, so select and size never move
	initial begin
		hsel = 1'b1;
		hsize = 3'h2;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	// both phases wait on hready, bounded so a dead slave cannot hang the run
	task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d, output logic [31:0] q, output bit to);
		int n;
		n = 0;
		@(posedge clk);
		haddr <= {22'h0, a};
		hwrite <= w;
		htrans <= SAR_HTRANS_NONSEQ;
		do @(posedge clk); while (!hready && ++n < 50);
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		do @(posedge clk); while (!hready && ++n < 50);
		q = hrdata;
		to = n >= 50;
	endtask : xfer
endmodule : sar_host

// ### test/sar_irq_sva.sv
/* checker for sar_irq ports. assumes it is bound onto sar_irq. */
module sar_irq_chk
	import sar_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire sar_events_t events,
	input wire sar_reads_t reads,
	input wire logic irq_x
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [15:0] st, ac, rt;
	logic wd, rd;
	logic [9:0] ad;
	wire ok = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[31:10] == 22'h0;
	wire [15:0] w = wd ? hwdata[15:0] : 16'h0;
	// shadow registers; a hardware set wins over both clears
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{st, ac, rt, wd, rd, ad} <= {16'h0, SAR_ACLEAR_RST, 16'h0, 12'h0};
		end else begin
			wd <= ok && hwrite;
			rd <= ok && !hwrite;
			ad <= haddr[9:0];
			st <= st & ~({reads.fifo_read, 3'h0, reads.slot_read} & ac) & ~(ad == SAR_ADDR_STATUS ? w : 16'h0)
				| {events[14:12], 1'b0, events.slot_ready};
			ac <= (wd && ad == SAR_ADDR_ACLEAR) ? w & SAR_ACLEAR_MASK : ac;
			rt <= (wd && ad == SAR_ADDR_ROUTE) ? w & SAR_ROUTE_MASK : rt;
		end
	end
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
	chk_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("hrdata upper half set");
	chk_irq_route: assert property (irq_x == $past(|(st & rt)))
		else $error("irq_x wrong");
	chk_status_read: assert property (rd && ad == SAR_ADDR_STATUS |-> hrdata[15:0] == $past(st))
		else $error("status read wrong");
	chk_aclear_read: assert property (rd && ad == SAR_ADDR_ACLEAR |-> hrdata[15:0] == $past(ac))
		else $error("autoclear read wrong");
	chk_route_read: assert property (rd && ad == SAR_ADDR_ROUTE |-> hrdata[15:0] == $past(rt))
		else $error("route read wrong");
	chk_reset_quiet: assert property ($fell(sys_rst) |-> !irq_x && hrdata == 32'h0)
		else $error("outputs not idle after reset");
	cover property (irq_x);
	cover property (rd && ad == SAR_ADDR_STATUS);
	cover property (|({reads.fifo_read, 3'h0, reads.slot_read} & ac & st));
endmodule : sar_irq_chk

bind sar_irq sar_irq_chk i_sar_irq_chk (.*);

// ### test/sar_irq_tb.sv
/* bench for sar_irq. assumes sar_host as bus master and the bound checker. */
module sar_irq_tb
	import sar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, sys_rst = 1, hsel, hwrite, hreadyout, hresp, irq_x;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	sar_events_t events = '0;
	sar_reads_t reads = '0;
	int n_mismatch = 0, samples_checked = 0;
	sar_irq i_sar_irq (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.events(events), .reads(reads), .irq_x(irq_x));
	sar_host i_sar_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	initial forever #12.5 clk = ~clk;
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic rw(input logic w, input logic [9:0] a, input logic [15:0] d);
		bit to;
		i_sar_host.xfer(w, a, d, q, to);
		if (to) begin
			n_mismatch++;
			close_out();
		end
	endtask : rw
	// one-cycle strobes in status layout, then time for irq_x to follow
	task automatic pulse(input logic [15:0] ev, input logic [15:0] rd);
		@(posedge clk);
		events <= {ev[15:13], ev[11:0]};
		reads <= {rd[15], rd[11:0]};
		@(posedge clk);
		events <= '0;
		reads <= '0;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse
	// reset values, then routing bit by bit, then autoclear on and off
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rw(0, SAR_ADDR_ACLEAR, 0);
		chk("aclear", q, 32'h8fff);
		rw(0, SAR_ADDR_ROUTE, 0);
		chk("route", q, 32'h0);
		rw(0, 10'h3c, 0);
		chk("unmapped", q, 32'h0);
		$display("test reset done");
		for (int b = 0; b < 16; b++) begin
			if (b == 12) continue;
			pulse(16'h1 << b, 0);
			chk("irq masked", irq_x, 0);
			rw(1, SAR_ADDR_ROUTE, 16'h1 << b);
			pulse(0, 0);
			chk("irq routed", irq_x, 1);
			rw(1, SAR_ADDR_STATUS, 16'hffff);
			pulse(0, 0);
			chk("irq cleared", irq_x, 0);
		end
		$display("test route done");
		rw(1, SAR_ADDR_ROUTE, 16'hefff);
		for (int k = 0; k < 2; k++) begin
			rw(1, SAR_ADDR_ACLEAR, k ? 16'h0 : 16'hffff);
			pulse(16'hefff, 0);
			pulse(0, 16'h8fff);
			rw(0, SAR_ADDR_STATUS, 0);
			chk("status", q, k ? 32'hefff : 32'h6000);
			chk("irq", irq_x, 1);
			rw(1, SAR_ADDR_STATUS, 16'hffff);
		end
		$display("test autoclear done");
		close_out();
	end
endmodule : sar_irq_tb
